// ===== logic/mdc_config_regs.sv
// Notes on behaviour
// - Status bits 7..0 report the eight fault conditions.
// - Set mask bit drives fault pin low.
// - Mask bit 12 makes overvoltage warning only.
// - Control bit 12 triggers open-load check in full bridge.
// - Bit 11 allows fast blanking in warning.
// - Bit 10 enables active current regulation in full bridge.
// - Outputs need bit 4, enable high, disable low.
// - Bit 3 selects full or half bridge.
// - Bit 2 selects virtual inputs over pins.
// - Bits 1,0 act as virtual input pins.
// - Half bridge limits protection per output.
// - Filtered undervoltage turns all transistors off.
// - Resume only after filtered supply recovery.
// - Frame bit 15 writes; bits 14:13 select.
// - Clear flags, except temperature warning, only when fault gone plus event.
// - Undervoltage filtered, at most ten microseconds.
`timescale 1ns/1ps
module mdc_config_regs
  import mdc_pkg::*;
#(
  parameter logic [4:0] DEVICE_ID = 5'h00 // Arbitrary value
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic enable_pin_i,
  input wire logic disable_pin_i,
  input wire logic input_pin_a_i,
  input wire logic input_pin_b_i,
  input wire logic supply_below_uv_i,
  input wire logic supply_above_ov_i,
  input wire logic pump_low_i,
  input wire logic [1:0] short_supply_i,
  input wire logic [1:0] short_ground_i,
  input wire logic open_load_i,
  input wire logic overcurrent_i,
  input wire logic temp_warning_state_i,
  input wire logic overtemp_i,
  output logic out1_high_o,
  output logic out1_low_o,
  output logic out2_high_o,
  output logic out2_low_o,
  output logic fault_out_n_o,
  output logic [1:0] current_limit_sel_o,
  output logic [2:0] slew_sel_o,
  output logic active_limit_o,
  output logic blanking_fast_o,
  output logic open_load_check_o
);

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  logic [SY_W-1:0] raw;
  logic [SY_W-1:0] sy;
  assign raw = {overtemp_i, temp_warning_state_i, overcurrent_i,
                open_load_i, short_ground_i[1], short_ground_i[0],
                short_supply_i[1], short_supply_i[0], pump_low_i,
                supply_above_ov_i, supply_below_uv_i, input_pin_b_i,
                input_pin_a_i, disable_pin_i, enable_pin_i, mosi_i,
                sclk_i, ~cs_n_i};
  // Select enters inverted so reset reads as idle, not a frame end
  mdc_sync_bank #(.WIDTH(SY_W)) u_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .async_i(raw),
    .sync_o(sy)
  );
  logic cs_d_reg, sclk_d_reg, enable_pin_d_reg, dis_d_reg;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_d_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
      enable_pin_d_reg <= 1'b0;
      dis_d_reg <= 1'b0;
    end else begin
      cs_d_reg <= sy[SY_CS_N];
      sclk_d_reg <= sy[SY_SCLK];
      enable_pin_d_reg <= sy[SY_ENABLE_PIN];
      dis_d_reg <= sy[SY_DIS];
    end
  end
  logic cs_fall, cs_rise, sclk_rise, sclk_fall, in_frame, clr_evt;
  assign cs_fall = ~cs_d_reg & sy[SY_CS_N];
  assign cs_rise = cs_d_reg & ~sy[SY_CS_N];
  assign in_frame = sy[SY_CS_N];
  assign sclk_rise = in_frame & ~sclk_d_reg & sy[SY_SCLK];
  assign sclk_fall = in_frame & sclk_d_reg & ~sy[SY_SCLK];
  assign clr_evt = (dis_d_reg & ~sy[SY_DIS]) |
                   (~enable_pin_d_reg & sy[SY_ENABLE_PIN]);

  // ---------------------------------------------------------------
  // Serial frame receive and transmit
  // ---------------------------------------------------------------
  logic [FRAME_BITS-1:0] rx_reg, tx_reg, resp_reg;
  logic [4:0] bit_cnt_reg;
  logic cnt_zero_reg;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_reg <= '0;
      bit_cnt_reg <= '0;
      cnt_zero_reg <= 1'b1;
    end else if (cs_fall) begin
      bit_cnt_reg <= '0;
      cnt_zero_reg <= 1'b1;
    end else if (sclk_rise) begin
      rx_reg <= {rx_reg[FRAME_BITS-2:0], sy[SY_MOSI]};
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      cnt_zero_reg <= 1'b0;
    end
  end

  // Frame decode happens on the deselect edge only
  logic frame_ok, frame_bad, wr_flags, wr_mask, wr_config;
  logic [1:0] sel;
  assign sel = rx_reg[FR_ADDR_HI:FR_ADDR_LO];
  assign frame_ok = cs_rise & ~cnt_zero_reg &
                    ((bit_cnt_reg & FRAME_CNT_MASK) == 5'h00);
  assign frame_bad = cs_rise & (~frame_ok |
                     (rx_reg[FR_WRITE] & (sel == REG_IDENT)));
  assign wr_flags = frame_ok & rx_reg[FR_WRITE] & (sel == REG_FLAGS);
  assign wr_mask = frame_ok & rx_reg[FR_WRITE] & (sel == REG_MASK);
  assign wr_config = frame_ok & rx_reg[FR_WRITE] &
                     (sel == REG_CONFIG);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [12:0] mask_reg;
  logic [12:0] config_reg;
  logic [11:0] flags_reg;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_reg <= MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= rx_reg[DATA_BITS-1:0];
    end
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      config_reg <= CONFIG_RESET;
    end else if (wr_config) begin
      config_reg <= rx_reg[DATA_BITS-1:0];
    end
  end
  logic mode_full, overvoltage_protect_disable;
  assign mode_full = config_reg[CF_MODE];
  assign overvoltage_protect_disable = mask_reg[MK_DOV];

  // ---------------------------------------------------------------
  // Supply undervoltage filter
  // ---------------------------------------------------------------
  // One counter serves both directions; it restarts whenever the
  // comparator agrees with the current state.
  logic [UV_CNT_W-1:0] uv_cnt_reg;
  logic uv_off_reg;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      uv_cnt_reg <= '0;
      uv_off_reg <= 1'b0;
    end else if (sy[SY_UV] == uv_off_reg) begin
      uv_cnt_reg <= '0;
    end else if (uv_cnt_reg == UV_CNT_W'(UV_FILTER_CYC - 1)) begin
      uv_cnt_reg <= '0;
      uv_off_reg <= sy[SY_UV];
    end else begin
      uv_cnt_reg <= uv_cnt_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Fault flags
  // ---------------------------------------------------------------
  logic [11:0] present;
  always_comb begin
    present = '0;
    present[ST_OT] = sy[SY_OT];
    present[ST_TW] = sy[SY_TW];
    present[ST_OC] = sy[SY_OC];
    present[ST_OL] = sy[SY_OL] & mode_full;
    present[ST_SHORT_GROUND_OUT1] = sy[SY_SHORT_GROUND_OUT1];
    present[ST_SHORT_GROUND_OUT2] = sy[SY_SHORT_GROUND_OUT2];
    present[ST_SHORT_SUPPLY_OUT1] = sy[SY_SHORT_SUPPLY_OUT1];
    present[ST_SHORT_SUPPLY_OUT2] = sy[SY_SHORT_SUPPLY_OUT2];
    present[ST_OV] = sy[SY_OV];
    present[ST_UV] = uv_off_reg;
    present[ST_CPU] = sy[SY_CPU];
    present[ST_FRM] = frame_bad;
  end

  logic [11:0] flag_clr;
  assign flag_clr = ({FLAG_BITS{clr_evt}} |
                     ({FLAG_BITS{wr_flags}} & rx_reg[FLAG_BITS-1:0])) &
                    ~present;

  // Temperature warning follows the live condition, never latches
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_reg <= FLAGS_RESET;
    end else begin
      flags_reg <= present | (flags_reg & ~flag_clr);
      flags_reg[ST_TW] <= present[ST_TW];
    end
  end

  // ---------------------------------------------------------------
  // Read-back: answer carries previous frame's register
  // ---------------------------------------------------------------
  logic [DATA_BITS-1:0] rd_data;
  always_comb begin
    unique case (sel)
      REG_IDENT: rd_data = {8'h00, DEVICE_ID};
      REG_FLAGS: rd_data = {1'b0, flags_reg};
      REG_MASK: rd_data = mask_reg;
      REG_CONFIG: rd_data = config_reg;
    endcase
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      resp_reg <= '0;
    end else if (frame_ok) begin
      resp_reg <= {1'b0, sel, rd_data};
    end
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_reg <= '0;
    end else if (cs_fall) begin
      tx_reg <= resp_reg;
    end else if (sclk_fall) begin
      tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
    end
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end else begin
      miso_o <= tx_reg[FRAME_BITS-1];
      miso_oe_o <= in_frame;
    end
  end

  // ---------------------------------------------------------------
  // Bridge control
  // ---------------------------------------------------------------
  logic cmd_a, cmd_b, drive_ok, ov_brake, limit_act, sc1, sc2;
  logic [1:0] lvl, on;
  assign cmd_a = config_reg[CF_INPUT] ? config_reg[CF_VIN_A] :
                 sy[SY_IN_A];
  assign cmd_b = config_reg[CF_INPUT] ? config_reg[CF_VIN_B] :
                 sy[SY_IN_B];
  assign drive_ok = config_reg[CF_EN] & sy[SY_ENABLE_PIN] & ~sy[SY_DIS] &
                    ~uv_off_reg & ~flags_reg[ST_OT];
  assign ov_brake = mode_full & ~overvoltage_protect_disable & sy[SY_OV];
  assign limit_act = mode_full & config_reg[CF_AL] &
                     sy[SY_OC];
  assign sc1 = flags_reg[ST_SHORT_SUPPLY_OUT1] | flags_reg[ST_SHORT_GROUND_OUT1];
  assign sc2 = flags_reg[ST_SHORT_SUPPLY_OUT2] | flags_reg[ST_SHORT_GROUND_OUT2];

  always_comb begin
    lvl = 2'h0;
    on = 2'h0;
    if (drive_ok) begin
      if (mode_full) begin
        on = (sc1 | sc2) ? 2'h0 : 2'h3;
        if (ov_brake | limit_act | ~cmd_b) begin
          lvl = 2'h3; // Recirculate through both high sides
        end else begin
          lvl = {~cmd_a, cmd_a};
        end
      end else begin
        on = {~sc2, ~sc1};
        lvl = {cmd_b, cmd_a};
      end
    end
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out1_high_o <= 1'b0;
      out1_low_o <= 1'b0;
      out2_high_o <= 1'b0;
      out2_low_o <= 1'b0;
    end else begin
      out1_high_o <= on[0] & lvl[0];
      out1_low_o <= on[0] & ~lvl[0];
      out2_high_o <= on[1] & lvl[1];
      out2_low_o <= on[1] & ~lvl[1];
    end
  end

  // ---------------------------------------------------------------
  // Open-load check, limit settings and fault pin
  // ---------------------------------------------------------------
  logic cl_d_reg, drive_d_reg;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cl_d_reg <= 1'b0;
      drive_d_reg <= 1'b0;
      open_load_check_o <= 1'b0;
    end else begin
      cl_d_reg <= config_reg[CF_CL];
      drive_d_reg <= drive_ok;
      open_load_check_o <= mode_full & config_reg[CF_CL] &
                           ((~cl_d_reg & ~drive_ok) |
                            (drive_ok & ~drive_d_reg));
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      current_limit_sel_o <= CONFIG_RESET[CF_ILIM_HI:CF_ILIM_LO];
      slew_sel_o <= CONFIG_RESET[CF_SR_HI:CF_SR_LO];
      active_limit_o <= 1'b0;
      blanking_fast_o <= 1'b0;
      fault_out_n_o <= 1'b1;
    end else begin
      current_limit_sel_o <= config_reg[CF_ILIM_HI:CF_ILIM_LO];
      slew_sel_o <= config_reg[CF_SR_HI:CF_SR_LO];
      active_limit_o <= limit_act & drive_ok;
      blanking_fast_o <= config_reg[CF_TM] & sy[SY_TW];
      fault_out_n_o <= ~|(flags_reg & mask_reg[FLAG_BITS-1:0]);
    end
  end

endmodule

// ===== logic/mdc_pkg.sv
package mdc_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int FR_WRITE = 15;
  localparam int FR_ADDR_HI = 14;
  localparam int FR_ADDR_LO = 13;
  localparam int DATA_BITS = 13;
  localparam logic [4:0] FRAME_CNT_MASK = 5'h0f;

  // ---------------------------------------------------------------
  // Register selection codes
  // ---------------------------------------------------------------
  localparam logic [1:0] REG_IDENT = 2'h0;
  localparam logic [1:0] REG_FLAGS = 2'h1;
  localparam logic [1:0] REG_MASK = 2'h2;
  localparam logic [1:0] REG_CONFIG = 2'h3;

  // ---------------------------------------------------------------
  // Status and mask bit positions
  // ---------------------------------------------------------------
  localparam int ST_OT = 0;
  localparam int ST_TW = 1;
  localparam int ST_OC = 2;
  localparam int ST_OL = 3;
  localparam int ST_SHORT_GROUND_OUT1 = 4;
  localparam int ST_SHORT_GROUND_OUT2 = 5;
  localparam int ST_SHORT_SUPPLY_OUT1 = 6;
  localparam int ST_SHORT_SUPPLY_OUT2 = 7;
  localparam int ST_OV = 8;
  localparam int ST_UV = 9;
  localparam int ST_CPU = 10;
  localparam int ST_FRM = 11;
  localparam int MK_DOV = 12;
  localparam int FLAG_BITS = 12;

  // ---------------------------------------------------------------
  // Configuration bit positions
  // ---------------------------------------------------------------
  localparam int CF_VIN_A = 0;
  localparam int CF_VIN_B = 1;
  localparam int CF_INPUT = 2;
  localparam int CF_MODE = 3;
  localparam int CF_EN = 4;
  localparam int CF_SR_LO = 5;
  localparam int CF_SR_HI = 7;
  localparam int CF_ILIM_LO = 8;
  localparam int CF_ILIM_HI = 9;
  localparam int CF_AL = 10;
  localparam int CF_TM = 11;
  localparam int CF_CL = 12;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [12:0] MASK_RESET = 13'h06f1;
  localparam logic [12:0] CONFIG_RESET = 13'h0d98;
  localparam logic [11:0] FLAGS_RESET = 12'h000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int UV_FILTER_US = 10;
  // Longest time: rounds down
  localparam int UV_FILTER_CYC = UV_FILTER_US * CLK_MHZ;
  localparam int UV_CNT_W = 10;

  // ---------------------------------------------------------------
  // Synchronised input vector layout
  // ---------------------------------------------------------------
  localparam int SY_CS_N = 0;
  localparam int SY_SCLK = 1;
  localparam int SY_MOSI = 2;
  localparam int SY_ENABLE_PIN = 3;
  localparam int SY_DIS = 4;
  localparam int SY_IN_A = 5;
  localparam int SY_IN_B = 6;
  localparam int SY_UV = 7;
  localparam int SY_OV = 8;
  localparam int SY_CPU = 9;
  localparam int SY_SHORT_SUPPLY_OUT1 = 10;
  localparam int SY_SHORT_SUPPLY_OUT2 = 11;
  localparam int SY_SHORT_GROUND_OUT1 = 12;
  localparam int SY_SHORT_GROUND_OUT2 = 13;
  localparam int SY_OL = 14;
  localparam int SY_OC = 15;
  localparam int SY_TW = 16;
  localparam int SY_OT = 17;
  localparam int SY_W = 18;

endpackage

// ===== logic/mdc_sync_bank.sv
`timescale 1ns/1ps
module mdc_sync_bank #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ---------------------------------------------------------------
  // Two-stage synchroniser per bit
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_reg;
      logic stable_reg;
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          meta_reg <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          meta_reg <= async_i[gi];
          stable_reg <= meta_reg;
        end
      end
      assign sync_o[gi] = stable_reg;
    end
  endgenerate

endmodule

// ===== verification/mdc_spi_host.sv
`timescale 1ns/1ps
module mdc_spi_host (
  input wire logic ref_clk_i,
  input wire logic miso_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o
);
  // Clock stands low outside frames; data shows the inverse when released
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end

  // MSB first, sampled on rise, 80 ns clock period
  task automatic xfer(input logic [15:0] cmd, input int nb,
                      output logic [15:0] rsp);
    rsp = 16'h0000;
    @(posedge ref_clk_i) cs_n_o <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    for (int i = nb - 1; i >= 0; i--) begin
      mosi_o <= cmd[i[3:0]];
      repeat (4) @(posedge ref_clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      // Taken late in the high phase, well after the last shift settled
      rsp = {rsp[14:0], miso_i};
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge ref_clk_i);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    // Gap well above 300 ns lets the register update land
    repeat (40) @(posedge ref_clk_i);
  endtask
endmodule

// ===== verification/mdc_config_regs_properties.sv
`timescale 1ns/1ps
module mdc_config_regs_properties (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic enable_pin_i,
  input wire logic disable_pin_i,
  input wire logic supply_below_uv_i,
  input wire logic overcurrent_i,
  input wire logic temp_warning_state_i,
  input wire logic miso_oe_o,
  input wire logic out1_high_o,
  input wire logic out1_low_o,
  input wire logic out2_high_o,
  input wire logic out2_low_o,
  input wire logic [1:0] current_limit_sel_o,
  input wire logic [2:0] slew_sel_o,
  input wire logic active_limit_o,
  input wire logic blanking_fast_o,
  input wire logic open_load_check_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [10:0] hi_cnt;
  logic [10:0] lo_cnt;
  logic tripped;
  logic [1:0] up_cnt;
  wire drive = out1_high_o | out1_low_o | out2_high_o | out2_low_o;
  // Saturating, so a long stall never wraps back under the bound
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hi_cnt <= 11'h000;
      lo_cnt <= 11'h000;
    end else begin
      hi_cnt <= supply_below_uv_i ? hi_cnt + {10'h000, ~&hi_cnt} : 11'h000;
      lo_cnt <= supply_below_uv_i ? 11'h000 : lo_cnt + {10'h000, ~&lo_cnt};
    end
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tripped <= 1'b0;
    end else if (hi_cnt >= 11'h3f2) begin
      tripped <= 1'b1;
    end else if (lo_cnt >= 11'h3f2) begin
      tripped <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_UV_OFF: assert property (hi_cnt >= 11'h3f2 |-> !drive)
    else $error("outputs on in undervoltage");
  AST_UV_RESUME: assert property (
    tripped && lo_cnt < 11'h3de |-> !drive)
    else $error("outputs resumed too early");
  AST_NO_ENABLE: assert property (!enable_pin_i [*6] |-> !drive)
    else $error("outputs on with enable low");
  AST_DISABLED: assert property (disable_pin_i [*6] |-> !drive)
    else $error("outputs on with disable high");
  AST_BLANK: assert property (
    !temp_warning_state_i [*6] |-> !blanking_fast_o)
    else $error("fast blanking without warning");
  AST_ACT_LIMIT: assert property (
    !overcurrent_i [*6] |-> !active_limit_o)
    else $error("regulation without overcurrent");
  AST_OE_IDLE: assert property (cs_n_i [*6] |-> !miso_oe_o)
    else $error("data out driven while deselected");
  AST_OE_FRAME: assert property (!cs_n_i [*6] |-> miso_oe_o)
    else $error("data out not driven in frame");
  AST_OL_PULSE: assert property (
    open_load_check_o |=> !open_load_check_o)
    else $error("open load request longer than one cycle");
  AST_FIELD_RST: assert property (up_cnt < 2'h3 |->
    current_limit_sel_o == 2'h1 && slew_sel_o == 3'h4)
    else $error("field defaults wrong after reset");
  cover property (tripped);
  cover property (open_load_check_o);
  cover property (active_limit_o);
  cover property (blanking_fast_o);
endmodule

bind mdc_config_regs mdc_config_regs_properties u_props (
  .ref_clk_i, .arst_n_i, .cs_n_i, .enable_pin_i, .disable_pin_i,
  .supply_below_uv_i, .overcurrent_i, .temp_warning_state_i,
  .miso_oe_o, .out1_high_o, .out1_low_o, .out2_high_o, .out2_low_o,
  .current_limit_sel_o, .slew_sel_o, .active_limit_o,
  .blanking_fast_o, .open_load_check_o
);

// ===== verification/mdc_config_regs_test.sv
`timescale 1ns/1ps
module mdc_config_regs_test
  import mdc_pkg::*;
();
  localparam logic [7:0] MK = 8'hf1;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cs_n, sclk, mosi, miso, miso_oe;
  logic en_pin = 1'b1;
  logic dis_pin = 1'b0;
  logic in_a = 1'b1;
  logic in_b = 1'b1;
  logic uv = 1'b0;
  logic ov = 1'b0;
  logic [7:0] flt = 8'h00;
  logic [3:0] g;
  logic fault_n, al_o, fast, ol_chk;
  logic ol_seen = 1'b0;
  logic [1:0] ilim;
  logic [2:0] slew;
  logic [15:0] rsp;
  wire miso_w = miso_oe ? miso : 1'bz;
  int miscompares = 0;
  int samples_checked = 0;

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (ol_chk === 1'b1) ol_seen <= 1'b1;

  mdc_config_regs dut (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .cs_n_i(cs_n),
    .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .enable_pin_i(en_pin), .disable_pin_i(dis_pin),
    .input_pin_a_i(in_a), .input_pin_b_i(in_b),
    .supply_below_uv_i(uv), .supply_above_ov_i(ov), .pump_low_i(1'b0),
    .short_supply_i(flt[7:6]), .short_ground_i(flt[5:4]),
    .open_load_i(flt[3]), .overcurrent_i(flt[2]),
    .temp_warning_state_i(flt[1]), .overtemp_i(flt[0]),
    .out1_high_o(g[3]), .out1_low_o(g[2]), .out2_high_o(g[1]),
    .out2_low_o(g[0]), .fault_out_n_o(fault_n),
    .current_limit_sel_o(ilim), .slew_sel_o(slew),
    .active_limit_o(al_o), .blanking_fast_o(fast),
    .open_load_check_o(ol_chk)
  );
  mdc_spi_host host (
    .ref_clk_i(ref_clk), .miso_i(miso_w), .cs_n_o(cs_n),
    .sclk_o(sclk), .mosi_o(mosi)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Gate vector: out1 high, out1 low, out2 high, out2 low
  task automatic gate(input logic [3:0] e, input string m);
    cyc(6);
    chk(16'(g), 16'(e), m);
  endtask
  task automatic wr(input logic [1:0] sel, input logic [12:0] d);
    host.xfer({1'b1, sel, d}, 16, rsp);
  endtask
  // Answer arrives in the frame after the one that addressed it
  task automatic rd(input logic [1:0] sel, input logic [12:0] e,
                    input string m);
    host.xfer({1'b0, sel, 13'h0000}, 16, rsp);
    host.xfer({1'b0, sel, 13'h0000}, 16, rsp);
    chk(rsp, {1'b0, sel, e}, m);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    chk(16'(ilim), 16'h0001, "ilim rst");
    chk(16'(slew), 16'h0004, "slew rst");
    rd(REG_MASK, 13'h06f1, "mask rst");
    rd(REG_CONFIG, 13'h0d98, "cfg rst");
    rd(REG_FLAGS, 13'h0000, "flags rst");
    wr(REG_CONFIG, 13'h0e78);
    chk(16'(ilim), 16'h0002, "ilim wr");
    chk(16'(slew), 16'h0003, "slew wr");
    rd(REG_CONFIG, 13'h0e78, "cfg wr");
    wr(REG_IDENT, 13'h0001);
    rd(REG_FLAGS, 13'h0800, "id write");
    wr(REG_FLAGS, 13'h0fff);
    host.xfer(16'h0000, 8, rsp);
    rd(REG_FLAGS, 13'h0800, "short frame");
    wr(REG_FLAGS, 13'h0fff);
    wr(REG_CONFIG, 13'h0d98);
  endtask

  task automatic t_flags();
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk) flt <= 8'(1 << i);
      rd(REG_FLAGS, 13'(1 << i), "flag");
      chk(16'(fault_n), 16'(!MK[i]), "pin");
      @(posedge ref_clk) flt <= 8'h00;
      wr(REG_FLAGS, 13'h0fff);
    end
    @(posedge ref_clk) flt <= 8'h01;
    wr(REG_FLAGS, 13'h0001);
    rd(REG_FLAGS, 13'h0001, "held");
    @(posedge ref_clk) flt <= 8'h00;
    rd(REG_FLAGS, 13'h0001, "latched");
    @(posedge ref_clk) dis_pin <= 1'b1;
    gate(4'b0000, "dis");
    @(posedge ref_clk) dis_pin <= 1'b0;
    rd(REG_FLAGS, 13'h0000, "dis clr");
    chk(16'(fault_n), 16'h0001, "pin off");
  endtask

  task automatic t_bridge();
    gate(4'b1001, "fwd");
    @(posedge ref_clk) in_a <= 1'b0;
    gate(4'b0110, "rev");
    @(posedge ref_clk) in_b <= 1'b0;
    gate(4'b1010, "brake");
    @(posedge ref_clk) in_a <= 1'b1;
    @(posedge ref_clk) in_b <= 1'b1;
    @(posedge ref_clk) ov <= 1'b1;
    gate(4'b1010, "ov brake");
    wr(REG_MASK, 13'h16f1);
    gate(4'b1001, "ov warn");
    wr(REG_MASK, 13'h06f1);
    @(posedge ref_clk) in_b <= 1'b0;
    wr(REG_CONFIG, 13'h0d90);
    gate(4'b1001, "half ov");
    @(posedge ref_clk) flt <= 8'h04;
    gate(4'b1001, "half oc");
    chk(16'(al_o), 16'h0000, "half al");
    @(posedge ref_clk) ov <= 1'b0;
    @(posedge ref_clk) in_b <= 1'b1;
    wr(REG_CONFIG, 13'h0d98);
    gate(4'b1010, "limit");
    chk(16'(al_o), 16'h0001, "al on");
    wr(REG_CONFIG, 13'h0998);
    gate(4'b1001, "no limit");
    chk(16'(al_o), 16'h0000, "al off");
    @(posedge ref_clk) flt <= 8'h00;
    wr(REG_CONFIG, 13'h0d9e);
    gate(4'b0110, "vin a");
    wr(REG_CONFIG, 13'h0d9d);
    gate(4'b1010, "vin b");
    wr(REG_CONFIG, 13'h0d88);
    gate(4'b0000, "en off");
    wr(REG_CONFIG, 13'h0d98);
    wr(REG_FLAGS, 13'h0fff);
  endtask

  task automatic t_uv();
    @(posedge ref_clk) uv <= 1'b1;
    cyc(900);
    gate(4'b1001, "uv filt");
    cyc(200);
    gate(4'b0000, "uv off");
    @(posedge ref_clk) uv <= 1'b0;
    cyc(900);
    gate(4'b0000, "uv hold");
    cyc(200);
    gate(4'b1001, "uv on");
    rd(REG_FLAGS, 13'h0200, "uv flag");
    wr(REG_FLAGS, 13'h0fff);
  endtask

  task automatic t_misc();
    @(posedge ref_clk) flt <= 8'h80;
    cyc(6);
    @(posedge ref_clk) flt <= 8'h00;
    @(posedge ref_clk) en_pin <= 1'b0;
    wr(REG_CONFIG, 13'h1d98);
    chk(16'(ol_seen), 16'h0001, "ol stby");
    ol_seen = 1'b0;
    @(posedge ref_clk) en_pin <= 1'b1;
    cyc(10);
    chk(16'(ol_seen), 16'h0001, "ol start");
    rd(REG_FLAGS, 13'h0000, "en clr");
    @(posedge ref_clk) flt <= 8'h02;
    cyc(6);
    chk(16'(fast), 16'h0001, "tm on");
    wr(REG_CONFIG, 13'h0598);
    chk(16'(fast), 16'h0000, "tm off");
    @(posedge ref_clk) flt <= 8'h00;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    cyc(4);
    t_regs();
    t_flags();
    t_bridge();
    t_uv();
    t_misc();
    stop_test();
  end
  // Whole run is near 14k cycles; this is several times that
  initial begin
    #1000000;
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
endmodule
